/* File: src/tsp_core_pipe.sv */
// Fetch and operand pipeline control of a small 32-bit core on a two-phase bus.
`timescale 1ns/1ps
module tsp_core_pipe (
    input  wire logic                  mclk_in,        // Core clock, 125 MHz
    input  wire logic                  sys_rst_in,     // Synchronous reset, active high
    input  wire logic                  start_valid_in, // Start address strobe from reset sequencer
    input  wire logic [31:0]           start_addr_in,  // First fetch address
    output tsp_pkg::tsp_bus_cmd_s      bus_cmd_out,    // Address phase command
    output logic      [31:0]           bus_wdata_out,  // Write data phase, registered
    input  wire logic [31:0]           bus_rdata_in,   // Read data phase
    input  wire logic                  bus_ready_in,   // Data phase completes
    output logic                       exec_valid_out, // Register result written last cycle
    output logic      [31:0]           exec_result_out // Execute result bus, registered
);
    typedef struct packed {
        logic [tsp_pkg::NREG-1:0][31:0]       regs;
        logic                                 fetch_en;
        logic [31:0]                          fetch_pc;
        logic                                 ic_v;
        logic [31:0]                          ic_pc;
        logic [tsp_pkg::FIFO_DEPTH-1:0][31:0] fq_word;
        logic [tsp_pkg::FIFO_DEPTH-1:0][31:0] fq_pc;
        logic [2:0]                           cnt;
        logic                                 ds_v;
        tsp_pkg::tsp_insn_s                   ds_ir;
        logic [31:0]                          ds_pc;
        logic                                 ag_v;
        tsp_pkg::tsp_insn_s                   ag_ir;
        logic [31:0]                          ag_pc;
        logic [31:0]                          ag_a;
        logic [31:0]                          ag_b;
        logic                                 ld_v;
        logic [3:0]                           ld_rd;
        logic [2:0]                           ld_mode;
        logic [1:0]                           ld_lane;
        logic                                 st_dp;
        logic [31:0]                          st_data;
        logic [1:0]                           st_busy;
        logic                                 zflag;
        logic                                 ex_v;
        logic [31:0]                          ex_res;
    } tsp_state_s;
    tsp_state_s         s_r;
    tsp_state_s         s_nxt;
    tsp_pkg::tsp_insn_s ag;
    tsp_pkg::tsp_insn_s ds;
    tsp_pkg::tsp_insn_s nxt_ir;
    logic [31:0]        ea;
    logic [31:0]        alu_res;
    logic [31:0]        sh_res;
    logic [31:0]        ld_data;
    logic [31:0]        ds_bt;
    logic [31:0]        redir_pc;
    logic [31:0]        nxt_pc;
    logic [31:0]        lane_d;
    logic [2:0]         occ;
    logic               hold;
    logic               alu_wr;
    logic               op_access;
    logic               ag_redirect;
    logic               ds_redirect;
    logic               ds_adv;
    logic               ds_fill;
    logic               st_enter;
    logic               fetch_issue;
    logic               fetch_arrive;
    logic               actual_taken;
    assign ag = s_r.ag_ir;
    assign ds = s_r.ds_ir;
    // Operand read with forwarding from execute and from the load data phase.
    function automatic logic [31:0] rd_fwd(input tsp_state_s st, input logic [3:0] idx, input logic aw,
                                           input logic [31:0] ares, input logic [31:0] ldat);
        logic [31:0] v;
        v = st.regs[idx];
        if (st.ld_v && st.ld_rd == idx) begin
            v = ldat;
        end
        if (aw && st.ag_ir.rd == idx) begin
            v = ares;
        end
        return v;
    endfunction

    tsp_shift_misc u_shifter_misc_engine (
        .op_in   (ag.op),
        .a_in    (s_r.ag_a),
        .b_in    (s_r.ag_b),
        .res_out (sh_res)
    );

    // ------------------------------------------------------------------
    // Execute stage and bus arbitration
    // ------------------------------------------------------------------
    always_comb begin
        ea = s_r.ag_a + {{16{ag.imm[tsp_pkg::IMM_SIGN]}}, ag.imm};
        unique case (ag.op)
            tsp_pkg::OP_ADD:  alu_res = s_r.ag_a + s_r.ag_b;
            tsp_pkg::OP_SUB:  alu_res = s_r.ag_a - s_r.ag_b;
            tsp_pkg::OP_AND:  alu_res = s_r.ag_a & s_r.ag_b;
            tsp_pkg::OP_OR:   alu_res = s_r.ag_a | s_r.ag_b;
            tsp_pkg::OP_XOR:  alu_res = s_r.ag_a ^ s_r.ag_b;
            tsp_pkg::OP_SHL, tsp_pkg::OP_SHR, tsp_pkg::OP_SAR, tsp_pkg::OP_MISC: alu_res = sh_res;
            default:          alu_res = ea;
        endcase
        alu_wr = s_r.ag_v && (ag.op <= tsp_pkg::OP_MISC || ag.op == tsp_pkg::OP_ADDI);
        // A stalled data phase freezes every stage; nothing new reaches the bus meanwhile.
        hold = (s_r.ic_v || s_r.ld_v || s_r.st_dp) && !bus_ready_in;
        op_access = s_r.ag_v && (ag.op == tsp_pkg::OP_LOAD || ag.op == tsp_pkg::OP_STORE) && !hold;
        actual_taken = ag.rd[tsp_pkg::BCC_NE_BIT] ? !s_r.zflag : s_r.zflag;
        ag_redirect = !hold && s_r.ag_v && (ag.op == tsp_pkg::OP_JMP ||
                      (ag.op == tsp_pkg::OP_BCC && actual_taken != ag.imm[tsp_pkg::IMM_SIGN]));
        if (ag.op == tsp_pkg::OP_BCC) begin
            redir_pc = actual_taken ? s_r.ag_b : s_r.ag_pc + tsp_pkg::FETCH_STRIDE;
        end else begin
            redir_pc = ea;
        end
        lane_d = bus_rdata_in >> {s_r.ld_lane, 3'h0};
        unique case (s_r.ld_mode[1:0])
            tsp_pkg::SZ_BYTE: ld_data = {{24{lane_d[7] & s_r.ld_mode[tsp_pkg::LD_SIGN_BIT]}}, lane_d[7:0]};
            tsp_pkg::SZ_WORD: ld_data = {{16{lane_d[15] & s_r.ld_mode[tsp_pkg::LD_SIGN_BIT]}}, lane_d[15:0]};
            default:          ld_data = lane_d;
        endcase
    end

    // ------------------------------------------------------------------
    // Stage advance, fetch and buffer
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        ds_bt = s_r.ds_pc + {{14{ds.imm[tsp_pkg::IMM_SIGN]}}, ds.imm, 2'h0};
        st_enter = 1'b0;
        ds_adv = 1'b0;
        ds_fill = 1'b0;
        ds_redirect = 1'b0;
        fetch_issue = 1'b0;
        fetch_arrive = 1'b0;
        nxt_ir = s_r.fq_word[0];
        nxt_pc = s_r.fq_pc[0];
        occ = 3'h0;
        bus_cmd_out = '0;
        s_nxt.ex_v = alu_wr && !hold;
        if (s_r.st_busy != 2'h0) begin
            s_nxt.st_busy = s_r.st_busy - 2'h1;
        end
        if (!s_r.fetch_en && start_valid_in) begin
            s_nxt.fetch_en = 1'b1;
            s_nxt.fetch_pc = start_addr_in;
        end
        if (!hold) begin
            // Execute stage retires; loads and stores start their address phase here.
            s_nxt.ag_v = 1'b0;
            s_nxt.ld_v = 1'b0;
            s_nxt.st_dp = 1'b0;
            if (s_r.ld_v) begin
                s_nxt.regs[s_r.ld_rd] = ld_data;
            end
            if (alu_wr) begin
                s_nxt.regs[ag.rd] = alu_res;
                s_nxt.zflag = (alu_res == 32'h00000000);
                s_nxt.ex_res = alu_res;
            end
            if (op_access) begin
                bus_cmd_out = '{req: 1'b1, write: (ag.op == tsp_pkg::OP_STORE), addr: ea};
                if (ag.op == tsp_pkg::OP_LOAD) begin
                    s_nxt.ld_v = 1'b1;
                    s_nxt.ld_rd = ag.rd;
                    s_nxt.ld_mode = ag.rb[2:0];
                    s_nxt.ld_lane = ea[1:0];
                end else begin
                    s_nxt.st_dp = 1'b1;
                    s_nxt.st_data = s_r.ag_b;
                end
            end
            // Decode stage: a store waits out the busy window, a branch may redirect early.
            ds_adv = s_r.ds_v && !ag_redirect && !(ds.op == tsp_pkg::OP_STORE && s_r.st_busy != 2'h0);
            if (ds_adv) begin
                s_nxt.ag_v = 1'b1;
                s_nxt.ag_ir = ds;
                s_nxt.ag_pc = s_r.ds_pc;
                s_nxt.ag_a = rd_fwd(s_r, ds.ra, alu_wr, alu_res, ld_data);
                s_nxt.ag_b = rd_fwd(s_r, (ds.op == tsp_pkg::OP_STORE) ? ds.rd : ds.rb, alu_wr, alu_res, ld_data);
                st_enter = (ds.op == tsp_pkg::OP_STORE);
                if (st_enter) begin
                    s_nxt.st_busy = tsp_pkg::STORE_BUSY_CY;
                end
                if (ds.op == tsp_pkg::OP_BCC) begin
                    s_nxt.ag_b = ds_bt;
                    ds_redirect = ds.imm[tsp_pkg::IMM_SIGN];
                end
            end
            if (ag_redirect || ds_redirect) begin
                s_nxt.cnt = 3'h0;
                s_nxt.ds_v = 1'b0;
                s_nxt.fetch_pc = ag_redirect ? redir_pc : ds_bt;
            end else begin
                fetch_arrive = s_r.ic_v;
                s_nxt.ds_v = s_r.ds_v && !ds_adv;
                // A load keeps decode occupied for its second cycle.
                ds_fill = (!s_r.ds_v || ds_adv) && !(ds_adv && ds.op == tsp_pkg::OP_LOAD)
                          && (s_r.cnt != 3'h0 || fetch_arrive);
                if (s_r.cnt == 3'h0) begin
                    nxt_ir = bus_rdata_in;
                    nxt_pc = s_r.ic_pc;
                end
                if (ds_fill) begin
                    s_nxt.ds_v = 1'b1;
                    s_nxt.ds_ir = nxt_ir;
                    s_nxt.ds_pc = nxt_pc;
                end
                if (ds_fill && s_r.cnt != 3'h0) begin
                    s_nxt.fq_word[0] = s_r.fq_word[1];
                    s_nxt.fq_word[1] = s_r.fq_word[2];
                    s_nxt.fq_pc[0] = s_r.fq_pc[1];
                    s_nxt.fq_pc[1] = s_r.fq_pc[2];
                    s_nxt.cnt = s_r.cnt - 3'h1;
                end
                if (fetch_arrive && !(ds_fill && s_r.cnt == 3'h0)) begin
                    s_nxt.fq_word[s_nxt.cnt[1:0]] = bus_rdata_in;
                    s_nxt.fq_pc[s_nxt.cnt[1:0]] = s_r.ic_pc;
                    s_nxt.cnt = s_nxt.cnt + 3'h1;
                end
                occ = s_nxt.cnt;
                fetch_issue = s_r.fetch_en && !op_access && occ < tsp_pkg::FIFO_DEPTH_C;
            end
            s_nxt.ic_v = fetch_issue;
            if (fetch_issue) begin
                bus_cmd_out = '{req: 1'b1, write: 1'b0, addr: s_r.fetch_pc};
                s_nxt.ic_pc = s_r.fetch_pc;
                s_nxt.fetch_pc = s_r.fetch_pc + tsp_pkg::FETCH_STRIDE;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r <= '0;
            s_r.fetch_pc <= tsp_pkg::RESET_PC;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_wdata_out = s_r.st_data;
    assign exec_valid_out = s_r.ex_v;
    assign exec_result_out = s_r.ex_res;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_fetch_yield:  assert property (op_access |-> !fetch_issue && bus_cmd_out.addr == ea)
        else $error("fetch issued beside an operand access");
    a_fetch_stride: assert property (fetch_issue ##1 (fetch_issue && !$past(ag_redirect || ds_redirect))
        |-> bus_cmd_out.addr == $past(bus_cmd_out.addr) + 32'h00000004)
        else $error("sequential fetch address not previous plus four");
    a_ic_hold:      assert property (s_r.ic_v && !bus_ready_in |=> s_r.ic_v && $stable(s_r.ic_pc))
        else $error("fetch capture left before data arrived");
    a_store_data:   assert property (op_access && bus_cmd_out.write
        |=> s_r.st_dp && bus_wdata_out == $past(s_r.ag_b))
        else $error("store data phase missing or wrong");
    a_load_phase:   assert property (op_access && !bus_cmd_out.write |=> s_r.ld_v && !s_r.ag_v)
        else $error("load did not occupy decode for two cycles");
    a_store_busy:   assert property (st_enter |=> !st_enter [*2])
        else $error("store entered inside the busy window");
    a_fifo_bound:   assert property (s_r.cnt <= 3'h3 && (s_r.cnt + {2'h0, s_r.ic_v}) <= 3'h3)
        else $error("instruction buffer overfilled");
    a_flush:        assert property (ag_redirect
        |=> s_r.cnt == 3'h0 && !s_r.ds_v && s_r.fetch_pc == $past(redir_pc))
        else $error("redirect did not flush and refetch");
    a_back_taken:   assert property (ds_adv && ds.op == tsp_pkg::OP_BCC && !ag_redirect
        |=> s_r.fetch_pc == ($past(ds.imm[15]) ? $past(ds_bt) : $past(s_r.fetch_pc + {29'h0, fetch_issue, 2'h0})))
        else $error("branch prediction did not steer the next fetch");
    a_idle_start:   assert property (!s_r.fetch_en |-> !bus_cmd_out.req)
        else $error("bus used before start address");

    c_load_store:   cover property (op_access && !bus_cmd_out.write ##2 op_access && bus_cmd_out.write);
    c_mispredict:   cover property (ag_redirect && ag.op == tsp_pkg::OP_BCC);
    c_fifo_full:    cover property (s_r.cnt == 3'h3);
    c_bypass:       cover property (ds_fill && s_r.cnt == 3'h0);
endmodule

/* File: src/tsp_pkg.sv */
// Shared constants and types of the two-stage core pipeline control.
package tsp_pkg;

    // ------------------------------------------------------------------
    // Datapath sizes and timing counts
    // ------------------------------------------------------------------
    localparam int          XLEN          = 32;
    localparam int          NREG          = 16;
    localparam int          FIFO_DEPTH    = 3;
    localparam logic [2:0]  FIFO_DEPTH_C  = 3'h3;
    localparam logic [31:0] FETCH_STRIDE  = 32'h00000004;
    localparam logic [1:0]  STORE_BUSY_CY = 2'h2;
    localparam logic [31:0] RESET_PC      = 32'h00000000;

    // ------------------------------------------------------------------
    // Instruction word layout and load size codes
    // ------------------------------------------------------------------
    localparam int         LD_SIGN_BIT = 2;
    localparam logic [1:0] SZ_BYTE     = 2'h0;
    localparam logic [1:0] SZ_WORD     = 2'h1;
    localparam int         BCC_NE_BIT  = 0;
    localparam int         IMM_SIGN    = 15;

    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_SAR,
        OP_MISC, OP_LOAD, OP_STORE, OP_BCC, OP_JMP, OP_ADDI, OP_NOP
    } tsp_op_e;

    typedef struct packed {
        tsp_op_e     op;
        logic [3:0]  rd;
        logic [3:0]  ra;
        logic [3:0]  rb;
        logic [15:0] imm;
    } tsp_insn_s;

    // ------------------------------------------------------------------
    // Platform bus address phase
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
    } tsp_bus_cmd_s;

endpackage

/* File: src/tsp_shift_misc.sv */
// Shifter and miscellaneous execute engine beside the main arithmetic unit.
`timescale 1ns/1ps
module tsp_shift_misc (
    input  wire tsp_pkg::tsp_op_e op_in,   // Shift or misc operation
    input  wire logic [31:0]      a_in,    // Value operand
    input  wire logic [31:0]      b_in,    // Shift amount operand
    output logic      [31:0]      res_out  // Engine result
);
    logic [4:0] amt;

    // barrel shifts plus a byte-reverse as the misc operation.
    always_comb begin
        amt = b_in[4:0];
        unique case (op_in)
            tsp_pkg::OP_SHL: res_out = a_in << amt;
            tsp_pkg::OP_SHR: res_out = a_in >> amt;
            tsp_pkg::OP_SAR: res_out = $unsigned($signed(a_in) >>> amt);
            default:         res_out = {a_in[7:0], a_in[15:8], a_in[23:16], a_in[31:24]};
        endcase
    end
endmodule

/* File: sim/tsp_mem_model.sv */
// Behavioural platform memory on the two-phase bus, with optional wait states.
`timescale 1ns/1ps
module tsp_mem_model (
    input  wire logic                  mclk_in,    // Core clock
    input  wire logic                  sys_rst_in, // Synchronous reset, active high
    input  wire tsp_pkg::tsp_bus_cmd_s cmd_in,     // Address phase from the core
    input  wire logic [31:0]           wdata_in,   // Write data phase from the core
    input  wire logic [1:0]            waits_in,   // Wait states added to every data phase
    output logic      [31:0]           rdata_out,  // Read data phase
    output logic                       ready_out   // Data phase completes
);
    logic [31:0] mem [0:255];
    logic        ph_v_r;
    logic        ph_wr_r;
    logic [7:0]  ph_idx_r;
    logic [1:0]  wait_r;
    logic [31:0] junk_r;

    // Outside a completing read the data lines carry a changing pattern, so a stale word is never mistaken for data.
    assign ready_out = ph_v_r && (wait_r == 2'h0);
    assign rdata_out = (ready_out && !ph_wr_r) ? mem[ph_idx_r] : junk_r;

    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ph_v_r <= 1'b0;
            wait_r <= 2'h0;
            junk_r <= 32'hA5C3_5A3C;
        end else begin
            junk_r <= ~junk_r;
            if (ph_v_r && wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else begin
                if (ph_v_r && ph_wr_r) begin
                    mem[ph_idx_r] <= wdata_in;
                end
                ph_v_r   <= cmd_in.req;
                ph_wr_r  <= cmd_in.write;
                ph_idx_r <= cmd_in.addr[9:2];
                wait_r   <= waits_in;
            end
        end
    end
endmodule

/* File: sim/tb_two_stage_core_pipeline.sv */
// Self-checking bench that runs a small program on the core against the memory model.
`timescale 1ns/1ps
module tb_two_stage_core_pipeline;
    logic                  mclk        = 1'b0;
    logic                  sys_rst     = 1'b1;
    logic                  start_valid = 1'b0;
    logic [31:0]           start_addr  = 32'h0000_0000;
    logic [1:0]            waits       = 2'h0;
    tsp_pkg::tsp_bus_cmd_s bus_cmd;
    logic [31:0]           bus_wdata;
    logic [31:0]           bus_rdata;
    logic                  bus_ready;
    logic                  exec_valid;
    logic [31:0]           exec_result;
    int                    fail_count  = 0;
    int                    comparisons = 0;
    int                    cycles      = 0;
    int                    store_gap   = 99;
    logic [31:0]           results [$];

    always #4 mclk = ~mclk;

    tsp_core_pipe uut (.mclk_in(mclk), .sys_rst_in(sys_rst), .start_valid_in(start_valid),
        .start_addr_in(start_addr), .bus_cmd_out(bus_cmd), .bus_wdata_out(bus_wdata), .bus_rdata_in(bus_rdata),
        .bus_ready_in(bus_ready), .exec_valid_out(exec_valid), .exec_result_out(exec_result));

    tsp_mem_model u_mem (.mclk_in(mclk), .sys_rst_in(sys_rst), .cmd_in(bus_cmd), .wdata_in(bus_wdata),
        .waits_in(waits), .rdata_out(bus_rdata), .ready_out(bus_ready));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] ins(input tsp_pkg::tsp_op_e op, input logic [3:0] rd, input logic [3:0] ra,
                                        input logic [3:0] rb, input logic [15:0] imm);
        return {op, rd, ra, rb, imm};
    endfunction

    // ------------------------------------------------------------------
    // Monitors
    // ------------------------------------------------------------------
    always @(negedge mclk) begin
        if (exec_valid === 1'b1) begin
            results.push_back(exec_result);
        end
        if (store_gap < 99) begin
            store_gap++;
        end
        if (bus_cmd.req === 1'b1 && bus_cmd.write === 1'b1) begin
            check(32'(store_gap >= 3), 32'h1, "store spacing");
            store_gap = 0;
        end
    end

    // The ceiling leaves ample margin over two program runs of a few hundred cycles each.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("wrong value at %0t: run did not finish", $time);
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_boot(input logic [1:0] w);
        logic [31:0] p [34];
        int          n;
        p = '{ins(tsp_pkg::OP_ADDI, 4'h1, 4'h0, 4'h0, 16'h0005), ins(tsp_pkg::OP_ADDI, 4'h2, 4'h1, 4'h0, 16'h0003),
            ins(tsp_pkg::OP_STORE, 4'h2, 4'h0, 4'h0, 16'h0100), ins(tsp_pkg::OP_STORE, 4'h1, 4'h0, 4'h0, 16'h0104),
            ins(tsp_pkg::OP_LOAD, 4'h3, 4'h0, 4'h2, 16'h0100), ins(tsp_pkg::OP_ADDI, 4'h4, 4'h3, 4'h0, 16'h0001),
            ins(tsp_pkg::OP_ADDI, 4'h5, 4'h0, 4'h0, 16'h0080), ins(tsp_pkg::OP_STORE, 4'h5, 4'h0, 4'h0, 16'h0108),
            ins(tsp_pkg::OP_LOAD, 4'h6, 4'h0, 4'h4, 16'h0108), ins(tsp_pkg::OP_ADDI, 4'h7, 4'h6, 4'h0, 16'h0000),
            ins(tsp_pkg::OP_LOAD, 4'h6, 4'h0, 4'h0, 16'h0108), ins(tsp_pkg::OP_ADDI, 4'h7, 4'h6, 4'h0, 16'h0000),
            ins(tsp_pkg::OP_ADDI, 4'h8, 4'h0, 4'h0, 16'h0002), ins(tsp_pkg::OP_ADDI, 4'h8, 4'h8, 4'h0, 16'hFFFF),
            ins(tsp_pkg::OP_BCC, 4'h1, 4'h0, 4'h0, 16'hFFFF), ins(tsp_pkg::OP_ADDI, 4'h9, 4'h0, 4'h0, 16'h0000),
            ins(tsp_pkg::OP_BCC, 4'h0, 4'h0, 4'h0, 16'h0002), ins(tsp_pkg::OP_ADDI, 4'hA, 4'h0, 4'h0, 16'h0BAD),
            ins(tsp_pkg::OP_ADDI, 4'hB, 4'h0, 4'h0, 16'h0066), ins(tsp_pkg::OP_JMP, 4'h0, 4'h0, 4'h0, 16'h0080),
            ins(tsp_pkg::OP_ADDI, 4'hC, 4'h0, 4'h0, 16'h0077), 32'hE000_0000, 32'hE000_0000, 32'hE000_0000,
            ins(tsp_pkg::OP_ADD, 4'hD, 4'h1, 4'h2, 16'h0000), ins(tsp_pkg::OP_SUB, 4'hE, 4'h1, 4'h2, 16'h0000),
            ins(tsp_pkg::OP_SAR, 4'hE, 4'hE, 4'h1, 16'h0000), ins(tsp_pkg::OP_SHR, 4'hE, 4'hE, 4'h1, 16'h0000),
            ins(tsp_pkg::OP_SHL, 4'hF, 4'h2, 4'h1, 16'h0000), ins(tsp_pkg::OP_MISC, 4'hF, 4'h5, 4'h0, 16'h0000),
            ins(tsp_pkg::OP_AND, 4'hF, 4'h1, 4'h2, 16'h0000), ins(tsp_pkg::OP_OR, 4'hF, 4'h1, 4'h2, 16'h0000),
            ins(tsp_pkg::OP_XOR, 4'hF, 4'h1, 4'h2, 16'h0000), ins(tsp_pkg::OP_JMP, 4'h0, 4'h0, 4'h0, 16'h00A4)};
        @(negedge mclk);
        sys_rst = 1'b1;
        waits   = w;
        for (int i = 0; i < 256; i++) begin
            u_mem.mem[i] = 32'hE000_0000;
        end
        for (int i = 0; i < 34; i++) begin
            u_mem.mem[8 + i] = p[i];
        end
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (6) begin
            @(negedge mclk);
            check({31'h0, bus_cmd.req}, 32'h0, "request before start");
            check({31'h0, exec_valid}, 32'h0, "result before start");
        end
        results.delete();
        start_valid = 1'b1;
        start_addr  = 32'h0000_0020;
        @(negedge mclk);
        check({bus_cmd.req, bus_cmd.write}, 32'h2, "first fetch phase");
        check(bus_cmd.addr, 32'h0000_0020, "first fetch address");
        start_valid = 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (bus_cmd.req !== 1'b1 && n < 12);
        check(bus_cmd.addr, 32'h0000_0024, "sequential fetch address");
    endtask

    task automatic t_program(input logic [1:0] w);
        logic [31:0] exp [20];
        int          n;
        exp = '{32'h5, 32'h8, 32'h9, 32'h80, 32'hFFFF_FF80, 32'h80, 32'h2, 32'h1, 32'h0, 32'h0, 32'h66, 32'hD,
            32'hFFFF_FFFD, 32'hFFFF_FFFF, 32'h07FF_FFFF, 32'h100, 32'h8000_0000, 32'h0, 32'hD, 32'hD};
        t_boot(w);
        n = 0;
        while (results.size() < 20 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        // Extra cycles let a wrongly executed skipped instruction show up as a surplus result.
        repeat (60) @(negedge mclk);
        check(32'(results.size()), 32'h14, "result count");
        for (int i = 0; i < 20 && i < results.size(); i++) begin
            check(results[i], exp[i], "execute result");
        end
        check(u_mem.mem[8'h40], 32'h8, "stored word");
        check(u_mem.mem[8'h41], 32'h5, "back-to-back store");
        check(u_mem.mem[8'h42], 32'h80, "third store");
    endtask

    initial begin
        t_program(2'h0);
        t_program(2'h2);
        print_verdict();
    end
endmodule
